// *** hdl/retimer_ctrl_pkg.sv ***
// Purpose: Shared constants and carriers for the retimer adaptation control registers
// Assumes: Byte-wide register port fed by the management serial engine
// Notes:   Offsets are byte addresses; all registers are eight bits wide
package retimer_ctrl_pkg;

  // Register offsets
  localparam logic [7:0] LOCK_QUAL_CTRL_ADDR = 8'h2f;
  localparam logic [7:0] INT_PAT_ADDR        = 8'h30;
  localparam logic [7:0] ADAPT_MODE_ADDR     = 8'h31;
  localparam logic [7:0] EYE_INT_THR_ADDR    = 8'h32;
  localparam logic [7:0] EYE_HANDOFF_ADDR    = 8'h33;
  localparam logic [7:0] TAP_LIMIT_ADDR      = 8'h34;
  localparam logic [7:0] FREQ_REQ_TAP1_ADDR  = 8'h35;
  localparam logic [7:0] IEN_CAP_ADDR        = 8'h36;
  localparam logic [7:0] LEQ_STATUS_ADDR     = 8'h37;
  localparam logic [7:0] FEQ_STATUS_ADDR     = 8'h38;

  // Values after reset
  localparam logic [7:0] LOCK_QUAL_CTRL_RST  = 8'h06;
  localparam logic [7:0] INT_PAT_RST         = 8'h00;
  localparam logic [7:0] ADAPT_MODE_RST      = 8'h40;
  localparam logic [7:0] EYE_INT_THR_RST     = 8'h11;
  localparam logic [7:0] EYE_HANDOFF_RST     = 8'h88;
  localparam logic [7:0] TAP_LIMIT_RST       = 8'h3f;
  localparam logic [7:0] FREQ_REQ_TAP1_RST   = 8'h1f;
  localparam logic [7:0] IEN_CAP_RST         = 8'h33;

  // Bits that software may write; the rest are kept by hardware
  localparam logic [7:0] LOCK_QUAL_CTRL_WMASK = 8'hfe;
  localparam logic [7:0] INT_PAT_WMASK        = 8'hcf;
  localparam logic [7:0] TAP_LIMIT_WMASK      = 8'h7f;

  // Field positions
  localparam int ADAPT_RUN_BIT    = 0;
  localparam int FDET_EN_BIT      = 1;
  localparam int PPM_EN_BIT       = 2;
  localparam int PAT_CLK_EN_BIT   = 3;
  localparam int CDR_IRQ_BIT      = 4;
  localparam int PAT_SEL_LSB      = 0;
  localparam int MODE_LSB         = 5;
  localparam int FOM_LSB          = 3;
  localparam int H_THR_LSB        = 4;
  localparam int V_THR_LSB        = 0;
  localparam int FREQ_READY_BIT   = 7;
  localparam int TAP25_LSB        = 0;
  localparam int FREQ_REQ_BIT     = 5;
  localparam int TAP1_LSB         = 0;
  localparam int EYE_IEN_BIT      = 6;
  localparam int CAP_OVR_BIT      = 2;
  localparam int CAP_RANGE_LSB    = 0;

  // Cycles taken by the frequency error computation
  localparam logic [3:0] FREQ_CALC_CYCLES = 4'h8;

  // Adaptation modes
  localparam logic [1:0] MODE_NONE     = 2'h0;
  localparam logic [1:0] MODE_LEQ_ONLY = 2'h1;
  localparam logic [1:0] MODE_LFL_OPT  = 2'h2;
  localparam logic [1:0] MODE_LFL_LOCK = 2'h3;

  // Figure of merit selections
  localparam logic [1:0] FOM_H_ONLY = 2'h1;
  localparam logic [1:0] FOM_V_ONLY = 2'h2;

  typedef enum logic [2:0] {ST_IDLE, ST_LEQ_FIRST, ST_FEQ, ST_LEQ_SECOND, ST_DONE} adapt_state_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // Measured eye openings
  typedef struct packed {
    logic [7:0] horz;
    logic [7:0] vert;
  } eye_meas_t;

endpackage : retimer_ctrl_pkg

// *** hdl/retimer_adaptation_control_regs.sv ***
// Purpose: Channel control and status registers for equalizer adaptation in a retimer
// Assumes: Register requests arrive one cycle wide from the management serial engine
// Notes:   Read data is registered and valid the cycle after a read request
// What this block does
// - Frequency lock detector qualifies recovery lock when its enable bit, default 1, is set.
// - Frequency error check qualifies lock when enable bit 2, default 1, is set.
// - Status bit 4 of register interrupt_and_pattern_ctrl rises when clock recovery raises its interrupt.
// - Bit 3 enables the pattern logic clock; bits 1:0 choose the pattern.
// - Two-bit adaptation mode selects none, linear only, or linear-feedback-linear sequences.
// - Figure of merit: 00/11 both openings, 01 horizontal only, 10 vertical only.
// - Eye interrupt compares horizontal opening against four times bits 7:4, gated by bit 6.
// - Eye interrupt compares vertical opening against four times bits 3:0.
// - Handoff to feedback adaptation needs horizontal opening against twice bits 7:4.
// - Second handoff threshold bits 3:0 times two also compares the horizontal opening.
// - Software sets bit 5 to request frequency error; device clears it and sets ready.
// - Feedback taps 2 to 5 are limited by bits 3:0, default 1111.
// - First feedback tap is limited by bits 4:0, default all ones.
// - Capacitor range override at bit 2 forces range from bits 1:0, default 11.
`timescale 1ns/1ps
module retimer_adaptation_control_regs (
  // Clock and reset
  input  wire logic                          CLK,
  input  wire logic                          RST_N,
  // Register port
  input  wire retimer_ctrl_pkg::reg_req_t    REG_REQ,
  output logic [7:0]                         REG_RDATA,
  output logic                               REG_RVALID,
  // Recovery and measurement inputs
  input  wire logic                          RAW_LOCK,
  input  wire logic                          FREQ_LOCKED,
  input  wire logic                          PPM_IN_RANGE,
  input  wire logic                          CDR_IRQ,
  input  wire retimer_ctrl_pkg::eye_meas_t   EYE_MEAS,
  input  wire logic [15:0]                   PPM_COUNT,
  input  wire logic [1:0]                    AUTO_CAP_RANGE,
  // Adaptation handshake
  input  wire logic                          ADAPT_START,
  input  wire logic                          LEQ_OPTIMAL,
  input  wire logic                          FEQ_DONE,
  input  wire logic [7:0]                    LEQ_STATUS,
  input  wire logic [7:0]                    FEQ_STATUS,
  // Control outputs
  output logic                               LOCK_OK,
  output logic                               PATTERN_CLK_EN,
  output logic [1:0]                         PATTERN_SELECT,
  output logic                               EYE_IRQ,
  output logic                               LEQ_ADAPT_EN,
  output logic                               FEQ_ADAPT_EN,
  output logic                               FOM_USE_H,
  output logic                               FOM_USE_V,
  output logic [3:0]                         TAP25_MAX,
  output logic [4:0]                         TAP1_MAX,
  output logic [1:0]                         CAP_RANGE,
  output logic [15:0]                        FREQ_ERROR
);
  import retimer_ctrl_pkg::*;

  logic         rst_meta_reg;
  logic         rst_n_sync;
  logic [7:0]   lock_qual_reg;
  logic [7:0]   int_pat_reg;
  logic [7:0]   adapt_mode_reg;
  logic [7:0]   eye_int_thr_reg;
  logic [7:0]   eye_handoff_reg;
  logic [7:0]   tap_limit_reg;
  logic [7:0]   freq_req_reg;
  logic [7:0]   ien_cap_reg;
  logic [3:0]   calc_cnt_reg;
  logic         calc_busy_reg;
  logic         calc_done;
  adapt_state_t state_reg;
  adapt_state_t state_next;
  logic         wr_lock_qual;
  logic         wr_int_pat;
  logic         wr_tap_limit;
  logic         wr_freq_req;
  logic         rd_int_pat;
  logic         handoff_ok;
  logic         lock_qualified;
  logic [7:0]   h_thr4;
  logic [7:0]   v_thr4;
  logic [7:0]   h_thr2;
  logic [7:0]   v_thr2;

  // Reset release through two flops so every flop leaves reset on the same edge
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_n_sync   <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_sync   <= rst_meta_reg;
    end
  end

  // Address decode for registers with side effects
  assign wr_lock_qual = REG_REQ.wr && (REG_REQ.addr == LOCK_QUAL_CTRL_ADDR);
  assign wr_int_pat   = REG_REQ.wr && (REG_REQ.addr == INT_PAT_ADDR);
  assign wr_tap_limit = REG_REQ.wr && (REG_REQ.addr == TAP_LIMIT_ADDR);
  assign wr_freq_req  = REG_REQ.wr && (REG_REQ.addr == FREQ_REQ_TAP1_ADDR);
  assign rd_int_pat   = REG_REQ.rd && (REG_REQ.addr == INT_PAT_ADDR);

  // Scaled thresholds; four bits times four never exceeds eight bits
  assign h_thr4 = {2'b00, eye_int_thr_reg[H_THR_LSB +: 4], 2'b00};
  assign v_thr4 = {2'b00, eye_int_thr_reg[V_THR_LSB +: 4], 2'b00};
  assign h_thr2 = {3'b000, eye_handoff_reg[H_THR_LSB +: 4], 1'b0};
  assign v_thr2 = {3'b000, eye_handoff_reg[V_THR_LSB +: 4], 1'b0};

  // Both handoff fields are held against the horizontal opening, as the device does
  assign handoff_ok = (EYE_MEAS.horz >= h_thr2) &&
                      (EYE_MEAS.horz >= v_thr2);

  // Disabled qualifiers pass through so lock rests on the remaining checks
  assign lock_qualified = RAW_LOCK &&
                          (!lock_qual_reg[FDET_EN_BIT] || FREQ_LOCKED) &&
                          (!lock_qual_reg[PPM_EN_BIT] || PPM_IN_RANGE);

  // Plain read/write control registers
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      adapt_mode_reg  <= ADAPT_MODE_RST;
      eye_int_thr_reg <= EYE_INT_THR_RST;
      eye_handoff_reg <= EYE_HANDOFF_RST;
      ien_cap_reg     <= IEN_CAP_RST;
    end else if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        ADAPT_MODE_ADDR:  adapt_mode_reg  <= REG_REQ.wdata;
        EYE_INT_THR_ADDR: eye_int_thr_reg <= REG_REQ.wdata;
        EYE_HANDOFF_ADDR: eye_handoff_reg <= REG_REQ.wdata;
        IEN_CAP_ADDR:     ien_cap_reg     <= REG_REQ.wdata;
        default: ;
      endcase
    end
  end

  // Lock qualifier register; bit 0 mirrors whether linear adaptation runs
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      lock_qual_reg <= LOCK_QUAL_CTRL_RST;
    end else begin
      if (wr_lock_qual) begin
        lock_qual_reg[7:1] <= REG_REQ.wdata[7:1] & LOCK_QUAL_CTRL_WMASK[7:1];
      end
      lock_qual_reg[ADAPT_RUN_BIT] <= (state_next == ST_LEQ_FIRST) ||
                                      (state_next == ST_LEQ_SECOND);
    end
  end

  // Interrupt and pattern register; the sticky recovery flag clears on read
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      int_pat_reg <= INT_PAT_RST;
    end else begin
      if (wr_int_pat) begin
        int_pat_reg <= (REG_REQ.wdata & INT_PAT_WMASK) | (int_pat_reg & ~INT_PAT_WMASK);
      end
      // A new event in the read cycle is kept so it is never lost
      if (CDR_IRQ) begin
        int_pat_reg[CDR_IRQ_BIT] <= 1'b1;
      end else if (rd_int_pat) begin
        int_pat_reg[CDR_IRQ_BIT] <= 1'b0;
      end
    end
  end

  // Tap limit register; ready flag belongs to hardware
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      tap_limit_reg <= TAP_LIMIT_RST;
    end else begin
      if (wr_tap_limit) begin
        tap_limit_reg[6:0] <= REG_REQ.wdata[6:0] & TAP_LIMIT_WMASK[6:0];
      end
      // A fresh request landing in the same cycle wins over completion
      if (calc_done) begin
        tap_limit_reg[FREQ_READY_BIT] <= 1'b1;
      end else if (wr_freq_req && REG_REQ.wdata[FREQ_REQ_BIT]) begin
        tap_limit_reg[FREQ_READY_BIT] <= 1'b0;
      end
    end
  end

  // Request bit: software sets, hardware clears; a fresh set wins over the clear
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      freq_req_reg <= FREQ_REQ_TAP1_RST;
    end else if (wr_freq_req) begin
      freq_req_reg <= REG_REQ.wdata;
    end else if (calc_done) begin
      freq_req_reg[FREQ_REQ_BIT] <= 1'b0;
    end
  end

  // Frequency error computation runs a fixed number of cycles per request
  assign calc_done = calc_busy_reg && (calc_cnt_reg == 4'h0) && !wr_freq_req;
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      calc_busy_reg <= 1'b0;
      calc_cnt_reg  <= 4'h0;
      FREQ_ERROR    <= 16'h0000;
    end else if (!calc_busy_reg && freq_req_reg[FREQ_REQ_BIT]) begin
      calc_busy_reg <= 1'b1;
      calc_cnt_reg  <= FREQ_CALC_CYCLES - 4'h1;
    end else if (calc_busy_reg && calc_cnt_reg != 4'h0) begin
      calc_cnt_reg  <= calc_cnt_reg - 4'h1;
    end else if (calc_done) begin
      calc_busy_reg <= 1'b0;
      FREQ_ERROR    <= PPM_COUNT;
    end
  end

  // Adaptation sequence selected by the mode field
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (ADAPT_START && adapt_mode_reg[MODE_LSB +: 2] != MODE_NONE) begin
          state_next = ST_LEQ_FIRST;
        end
      end
      ST_LEQ_FIRST: begin
        case (adapt_mode_reg[MODE_LSB +: 2])
          MODE_LEQ_ONLY: if (LEQ_OPTIMAL) state_next = ST_DONE;
          MODE_LFL_OPT:  if (LEQ_OPTIMAL && handoff_ok) state_next = ST_FEQ;
          MODE_LFL_LOCK: if (lock_qualified && handoff_ok) state_next = ST_FEQ;
          default:       state_next = ST_IDLE;
        endcase
      end
      ST_FEQ: begin
        if (FEQ_DONE) begin
          state_next = ST_LEQ_SECOND;
        end
      end
      ST_LEQ_SECOND: begin
        if (LEQ_OPTIMAL) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        if (ADAPT_START) begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  // Sequencer state; a start in done returns to idle, and a further start is needed to run again
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Adaptation enables and figure of merit selection
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      LEQ_ADAPT_EN <= 1'b0;
      FEQ_ADAPT_EN <= 1'b0;
      FOM_USE_H    <= 1'b1;
      FOM_USE_V    <= 1'b1;
    end else begin
      LEQ_ADAPT_EN <= (state_next == ST_LEQ_FIRST) || (state_next == ST_LEQ_SECOND);
      FEQ_ADAPT_EN <= (state_next == ST_FEQ);
      FOM_USE_H    <= (adapt_mode_reg[FOM_LSB +: 2] != FOM_V_ONLY);
      FOM_USE_V    <= (adapt_mode_reg[FOM_LSB +: 2] != FOM_H_ONLY);
    end
  end

  // Lock, pattern, interrupt, tap limit and capacitor range outputs
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      LOCK_OK        <= 1'b0;
      PATTERN_CLK_EN <= 1'b0;
      PATTERN_SELECT <= 2'h0;
      EYE_IRQ        <= 1'b0;
      TAP25_MAX      <= 4'h0;
      TAP1_MAX       <= 5'h00;
      CAP_RANGE      <= 2'h0;
    end else begin
      LOCK_OK        <= lock_qualified;
      PATTERN_CLK_EN <= int_pat_reg[PAT_CLK_EN_BIT];
      PATTERN_SELECT <= int_pat_reg[PAT_SEL_LSB +: 2];
      EYE_IRQ        <= ien_cap_reg[EYE_IEN_BIT] &&
                        ((EYE_MEAS.horz < h_thr4) ||
                         (EYE_MEAS.vert < v_thr4));
      TAP25_MAX      <= tap_limit_reg[TAP25_LSB +: 4];
      TAP1_MAX       <= freq_req_reg[TAP1_LSB +: 5];
      CAP_RANGE      <= ien_cap_reg[CAP_OVR_BIT] ? ien_cap_reg[CAP_RANGE_LSB +: 2]
                                                 : AUTO_CAP_RANGE;
    end
  end

  // Read port; unmapped addresses return zero
  always_ff @(posedge CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      REG_RDATA  <= 8'h00;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_REQ.rd;
      if (REG_REQ.rd) begin
        case (REG_REQ.addr)
          LOCK_QUAL_CTRL_ADDR: REG_RDATA <= lock_qual_reg;
          INT_PAT_ADDR:        REG_RDATA <= int_pat_reg;
          ADAPT_MODE_ADDR:     REG_RDATA <= adapt_mode_reg;
          EYE_INT_THR_ADDR:    REG_RDATA <= eye_int_thr_reg;
          EYE_HANDOFF_ADDR:    REG_RDATA <= eye_handoff_reg;
          TAP_LIMIT_ADDR:      REG_RDATA <= tap_limit_reg;
          FREQ_REQ_TAP1_ADDR:  REG_RDATA <= freq_req_reg;
          IEN_CAP_ADDR:        REG_RDATA <= ien_cap_reg;
          LEQ_STATUS_ADDR:     REG_RDATA <= LEQ_STATUS;
          FEQ_STATUS_ADDR:     REG_RDATA <= FEQ_STATUS;
          default:             REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

endmodule : retimer_adaptation_control_regs

// *** tb/retimer_ctrl_assertions.sv ***
// Purpose: Port-level timing checks for the adaptation control registers
// Assumes: Internal reset trails RST_N by two edges
// Notes:   Field checks follow writes seen at the register port
`timescale 1ns/1ps
module retimer_ctrl_assertions (
  // Clock and reset
  input wire logic                        CLK,
  input wire logic                        RST_N,
  // Register port
  input wire retimer_ctrl_pkg::reg_req_t  REG_REQ,
  input wire logic                        REG_RVALID,
  // Lock and eye inputs
  input wire logic                        RAW_LOCK,
  input wire logic                        FREQ_LOCKED,
  input wire logic                        PPM_IN_RANGE,
  input wire retimer_ctrl_pkg::eye_meas_t EYE_MEAS,
  // Control outputs
  input wire logic                        LOCK_OK,
  input wire logic                        PATTERN_CLK_EN,
  input wire logic [1:0]                  PATTERN_SELECT,
  input wire logic                        EYE_IRQ,
  input wire logic                        LEQ_ADAPT_EN,
  input wire logic                        FEQ_ADAPT_EN,
  input wire logic                        FOM_USE_H,
  input wire logic                        FOM_USE_V,
  input wire logic [3:0]                  TAP25_MAX,
  input wire logic [4:0]                  TAP1_MAX
);
  import retimer_ctrl_pkg::*;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  AST_RD_ANSWER: assert property (REG_REQ.rd |=> REG_RVALID)
    else $error("read got no valid strobe");
  AST_RVALID_CAUSE: assert property (!REG_REQ.rd |=> !REG_RVALID)
    else $error("valid strobe without a read");
  AST_LOCK_RAW: assert property (!RAW_LOCK |=> !LOCK_OK)
    else $error("lock without raw lock");
  AST_LOCK_ALL: assert property (RAW_LOCK && FREQ_LOCKED && PPM_IN_RANGE |=> LOCK_OK)
    else $error("lock missing with all qualifiers met");
  AST_FOM_ANY: assert property (FOM_USE_H || FOM_USE_V)
    else $error("figure of merit uses no opening");
  AST_ONE_EQ: assert property (!(LEQ_ADAPT_EN && FEQ_ADAPT_EN))
    else $error("both equalizers adapting");
  AST_FEQ_HANDOFF: assert property ($rose(FEQ_ADAPT_EN) |-> $past(LEQ_ADAPT_EN))
    else $error("feedback adaptation not entered from linear");
  AST_EYE_WIDE: assert property (EYE_MEAS == 16'hffff |=> !EYE_IRQ)
    else $error("eye interrupt on a wide open eye");
  AST_PAT_WRITE: assert property (REG_REQ.wr && REG_REQ.addr == INT_PAT_ADDR |->
    ##2 {PATTERN_CLK_EN, PATTERN_SELECT} == $past({REG_REQ.wdata[3], REG_REQ.wdata[1:0]}, 2))
    else $error("pattern outputs do not follow write");
  AST_TAP25_WRITE: assert property (REG_REQ.wr && REG_REQ.addr == TAP_LIMIT_ADDR |->
    ##2 TAP25_MAX == $past(REG_REQ.wdata[3:0], 2))
    else $error("tap limit does not follow write");
  AST_TAP1_WRITE: assert property (REG_REQ.wr && REG_REQ.addr == FREQ_REQ_TAP1_ADDR |->
    ##2 TAP1_MAX == $past(REG_REQ.wdata[4:0], 2))
    else $error("first tap limit does not follow write");
endmodule : retimer_ctrl_assertions

bind retimer_adaptation_control_regs retimer_ctrl_assertions u_chk (.CLK(CLK), .RST_N(RST_N),
  .REG_REQ(REG_REQ), .REG_RVALID(REG_RVALID), .RAW_LOCK(RAW_LOCK), .FREQ_LOCKED(FREQ_LOCKED),
  .PPM_IN_RANGE(PPM_IN_RANGE), .EYE_MEAS(EYE_MEAS), .LOCK_OK(LOCK_OK),
  .PATTERN_CLK_EN(PATTERN_CLK_EN), .PATTERN_SELECT(PATTERN_SELECT), .EYE_IRQ(EYE_IRQ),
  .LEQ_ADAPT_EN(LEQ_ADAPT_EN), .FEQ_ADAPT_EN(FEQ_ADAPT_EN), .FOM_USE_H(FOM_USE_H),
  .FOM_USE_V(FOM_USE_V), .TAP25_MAX(TAP25_MAX), .TAP1_MAX(TAP1_MAX));

// *** tb/eq_partner_model.sv ***
// Purpose: Equalizer side that answers the adaptation enables
// Assumes: Enables are registered levels from the register block
// Notes:   Results drop on the edge after adaptation stops, when the cycle count restarts
`timescale 1ns/1ps
module eq_partner_model #(
  parameter int LEQ_CYCLES = 5,
  parameter int FEQ_CYCLES = 7
) (
  // Clock
  input  wire logic clk,
  // Adaptation enables
  input  wire logic leq_adapt_en,
  input  wire logic feq_adapt_en,
  // Equalizer results
  output logic      leq_optimal,
  output logic      feq_done
);
  logic [7:0] leq_cnt_reg;
  logic [7:0] feq_cnt_reg;
  // Count cycles spent adapting; restart whenever an enable drops
  always_ff @(posedge clk) begin
    leq_cnt_reg <= leq_adapt_en ? leq_cnt_reg + 8'h01 : 8'h00;
    feq_cnt_reg <= feq_adapt_en ? feq_cnt_reg + 8'h01 : 8'h00;
  end
  assign leq_optimal = (leq_cnt_reg >= 8'(LEQ_CYCLES));
  assign feq_done    = (feq_cnt_reg >= 8'(FEQ_CYCLES));
endmodule : eq_partner_model

// *** tb/tb.sv ***
// Purpose: Register-level tests of the adaptation control block
// Assumes: Byte port with one-cycle requests and a read answer one edge later
// Notes:   Equalizer results come from the partner model
`timescale 1ns/1ps
module tb;
  import retimer_ctrl_pkg::*;
  logic       CLK = 1'b0, RST_N = 1'b0, RAW_LOCK = 1'b0, FREQ_LOCKED = 1'b0;
  logic       PPM_IN_RANGE = 1'b0, CDR_IRQ = 1'b0, ADAPT_START = 1'b0;
  reg_req_t   REG_REQ = '0;
  eye_meas_t  EYE_MEAS = 16'hffff;
  logic [15:0] PPM_COUNT = 16'h0000;
  logic [1:0] AUTO_CAP_RANGE = 2'h1;
  logic [7:0] LEQ_STATUS = 8'ha5, FEQ_STATUS = 8'h5a, REG_RDATA, rd;
  logic       REG_RVALID, LOCK_OK, PATTERN_CLK_EN, EYE_IRQ, LEQ_ADAPT_EN, FEQ_ADAPT_EN;
  logic       FOM_USE_H, FOM_USE_V, LEQ_OPTIMAL, FEQ_DONE;
  logic [1:0] PATTERN_SELECT, CAP_RANGE;
  logic [3:0] TAP25_MAX;
  logic [4:0] TAP1_MAX;
  logic [15:0] FREQ_ERROR;
  int         failures = 0;
  int         cmp_count = 0;
  // Expected reset contents of 0x2f..feedback_eq_status, status bytes as driven
  logic [7:0] rst_tab [10] = '{8'h06, 8'h00, 8'h40, 8'h11, 8'h88, 8'h3f, 8'h1f, 8'h33,
                               8'ha5, 8'h5a};
  // Qualifier enables, frequency lock, frequency check, expected lock
  logic [10:0] lk_tab [6] = '{{8'h00, 3'b001}, {8'h06, 3'b010}, {8'h06, 3'b100},
                              {8'h06, 3'b111}, {8'h02, 3'b101}, {8'h04, 3'b011}};
  // Horizontal opening, vertical opening, expected interrupt
  logic [16:0] eye_tab [4] = '{{16'h07ff, 1'b1}, {16'h08ff, 1'b0}, {16'hff03, 1'b1},
                               {16'hff04, 1'b0}};

  always #50 CLK = ~CLK;

  retimer_adaptation_control_regs dut (.CLK(CLK), .RST_N(RST_N), .REG_REQ(REG_REQ),
    .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .RAW_LOCK(RAW_LOCK),
    .FREQ_LOCKED(FREQ_LOCKED), .PPM_IN_RANGE(PPM_IN_RANGE), .CDR_IRQ(CDR_IRQ),
    .EYE_MEAS(EYE_MEAS), .PPM_COUNT(PPM_COUNT), .AUTO_CAP_RANGE(AUTO_CAP_RANGE),
    .ADAPT_START(ADAPT_START), .LEQ_OPTIMAL(LEQ_OPTIMAL), .FEQ_DONE(FEQ_DONE),
    .LEQ_STATUS(LEQ_STATUS), .FEQ_STATUS(FEQ_STATUS), .LOCK_OK(LOCK_OK),
    .PATTERN_CLK_EN(PATTERN_CLK_EN), .PATTERN_SELECT(PATTERN_SELECT), .EYE_IRQ(EYE_IRQ),
    .LEQ_ADAPT_EN(LEQ_ADAPT_EN), .FEQ_ADAPT_EN(FEQ_ADAPT_EN), .FOM_USE_H(FOM_USE_H),
    .FOM_USE_V(FOM_USE_V), .TAP25_MAX(TAP25_MAX), .TAP1_MAX(TAP1_MAX),
    .CAP_RANGE(CAP_RANGE), .FREQ_ERROR(FREQ_ERROR));

  eq_partner_model u_eq (.clk(CLK), .leq_adapt_en(LEQ_ADAPT_EN),
    .feq_adapt_en(FEQ_ADAPT_EN), .leq_optimal(LEQ_OPTIMAL), .feq_done(FEQ_DONE));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Register write and output settling: one edge to the register, one to the output flop
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    REG_REQ <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge CLK);
    REG_REQ <= '0;
  endtask : wr

  task automatic settle;
    repeat (2) @(posedge CLK);
    #1;
  endtask : settle

  // Read answer is looked at just after the edge that takes the request
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK);
    REG_REQ <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge CLK);
    REG_REQ <= '0;
    #1;
    chk(16'(REG_RVALID), 16'h0001);
    d = REG_RDATA;
  endtask : rd_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd_reg(a, d);
    chk(16'(d), 16'(exp));
  endtask : rd_chk

  // Start one adaptation run and record which phases were entered
  task automatic adapt(input logic [1:0] m, input logic [7:0] h, input logic [1:0] exp);
    logic [1:0] seen;
    seen = 2'b00;
    @(posedge CLK);
    EYE_MEAS <= '{horz: h, vert: 8'hff};
    wr(ADAPT_MODE_ADDR, {1'b0, m, 5'h00});
    @(posedge CLK);
    ADAPT_START <= 1'b1;
    @(posedge CLK);
    ADAPT_START <= 1'b0;
    repeat (40) begin
      @(posedge CLK);
      #1;
      seen = seen | {LEQ_ADAPT_EN, FEQ_ADAPT_EN};
    end
    chk(16'(seen), 16'(exp));
    wr(ADAPT_MODE_ADDR, 8'h00);
    @(posedge CLK);
    ADAPT_START <= 1'b1;
    @(posedge CLK);
    ADAPT_START <= 1'b0;
  endtask : adapt

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // Watchdog: the tests need under five hundred cycles
  initial begin
    #(100 * 20000);
    failures++;
    print_verdict;
  end

  initial begin
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CLK);
    for (int i = 0; i < 10; i++) begin
      rd_chk(8'h2f + 8'(i), rst_tab[i]);
    end
    chk(16'({TAP25_MAX, TAP1_MAX, CAP_RANGE}), 16'h07fd);
    wr(LEQ_STATUS_ADDR, 8'h00);
    wr(8'h50, 8'hff);
    rd_chk(LEQ_STATUS_ADDR, 8'ha5);
    rd_chk(8'h50, 8'h00);
    // Pattern controls, read-only bits and the sticky recovery flag
    wr(INT_PAT_ADDR, 8'hff);
    settle;
    chk(16'({PATTERN_CLK_EN, PATTERN_SELECT}), 16'h0007);
    rd_chk(INT_PAT_ADDR, 8'hcf);
    @(posedge CLK);
    CDR_IRQ <= 1'b1;
    @(posedge CLK);
    CDR_IRQ <= 1'b0;
    rd_chk(INT_PAT_ADDR, 8'hdf);
    rd_chk(INT_PAT_ADDR, 8'hcf);
    wr(INT_PAT_ADDR, 8'h01);
    settle;
    chk(16'({PATTERN_CLK_EN, PATTERN_SELECT}), 16'h0001);
    // Lock qualifiers in every enable combination
    @(posedge CLK);
    RAW_LOCK <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wr(LOCK_QUAL_CTRL_ADDR, lk_tab[i][10:3]);
      @(posedge CLK);
      FREQ_LOCKED <= lk_tab[i][2];
      PPM_IN_RANGE <= lk_tab[i][1];
      settle;
      chk(16'(LOCK_OK), 16'(lk_tab[i][0]));
    end
    for (int f = 0; f < 4; f++) begin
      wr(ADAPT_MODE_ADDR, 8'(f << 3));
      settle;
      chk(16'({FOM_USE_H, FOM_USE_V}), (f == 1) ? 16'h2 : (f == 2) ? 16'h1 : 16'h3);
    end
    // Eye interrupt at each threshold edge, then masked
    wr(EYE_INT_THR_ADDR, 8'h21);
    wr(IEN_CAP_ADDR, 8'h73);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      EYE_MEAS <= eye_tab[i][16:1];
      settle;
      chk(16'(EYE_IRQ), 16'(eye_tab[i][0]));
    end
    chk(16'(CAP_RANGE), 16'h0001);
    @(posedge CLK);
    EYE_MEAS <= 16'h0000;
    wr(IEN_CAP_ADDR, 8'h37);
    settle;
    chk(16'({EYE_IRQ, CAP_RANGE}), 16'h0003);
    // Tap limits, then a frequency error request that clears itself
    wr(TAP_LIMIT_ADDR, 8'h85);
    wr(FREQ_REQ_TAP1_ADDR, 8'h0a);
    settle;
    chk(16'({TAP25_MAX, TAP1_MAX}), 16'h00aa);
    rd_chk(TAP_LIMIT_ADDR, 8'h05);
    @(posedge CLK);
    PPM_COUNT <= 16'h1234;
    wr(FREQ_REQ_TAP1_ADDR, 8'h2a);
    rd_reg(FREQ_REQ_TAP1_ADDR, rd);
    chk(16'(rd), 16'h002a);
    for (int i = 0; i < 20 && !rd[7]; i++) begin
      rd_reg(TAP_LIMIT_ADDR, rd);
    end
    chk(16'(rd), 16'h0085);
    chk(FREQ_ERROR, 16'h1234);
    rd_chk(FREQ_REQ_TAP1_ADDR, 8'h0a);
    // Adaptation modes and both handoff thresholds
    wr(EYE_HANDOFF_ADDR, 8'h42);
    adapt(2'h2, 8'h07, 2'b10);
    wr(EYE_HANDOFF_ADDR, 8'h24);
    adapt(2'h2, 8'h07, 2'b10);
    adapt(2'h2, 8'h08, 2'b11);
    adapt(2'h0, 8'hff, 2'b00);
    adapt(2'h1, 8'hff, 2'b10);
    adapt(2'h3, 8'hff, 2'b11);
    print_verdict;
  end
endmodule : tb
